// >>> design/ofd_decoder.sv
// Operand field decoder for a 16-bit instruction word core.
// Assumes the fetch stage marks the format class and the second word.
// Strobes are combinational; the status flags, table pointer and table latch are held here.
// Summary of operation
// RL1: Access bit 0 selects access RAM, ignores bank
// RL2: Access bit 1 uses bank select with address
// RL3: Three-bit field selects bit 0 to 7
// RL4: Destination bit picks accumulator or file register
// RL5: File field is 8-bit address or pointer
// RL6: Two-word move carries 12-bit source, destination
// RL7: Literals decode as 8, 12 or 20 bits
// RL8: Fast bit 1 uses shadows, 0 leaves them
// RL9: Table pointer mode: hold, post-inc, post-dec, pre-inc
// RL10: Hold 21-bit table pointer and 8-bit latch
// RL11: Branch field is signed offset or absolute
// RL12: 7-bit index offsets added to indirect pointer
// RL13: Don't-care bits must not change behaviour
// RL14: Keep carry, digit carry, zero, overflow, negative
// RL15: Second word has ones on top, alone NOP
// RL16: Operands valid in the issuing instruction cycle
`timescale 1ns/1ps
module ofd_decoder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] prev_word,
  input wire logic second_slot,
  input wire ofd_pkg::ofd_fmt_e fmt,
  input wire ofd_pkg::ofd_litw_e lit_width,
  input wire logic branch_rel,
  input wire logic [10:0] branch_rel_w,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] indirect_pointer_register,
  input wire logic flags_we,
  input wire ofd_pkg::ofd_flags_s flags_in,
  input wire ofd_pkg::ofd_flags_s flags_mask,
  input wire logic ptr_load,
  input wire logic [ofd_pkg::TPTR_W-1:0] ptr_load_val,
  input wire logic latch_load,
  input wire logic [7:0] latch_load_val,
  output ofd_pkg::ofd_ops_s ops,
  output logic ops_valid,
  output logic wr_accumulator,
  output logic wr_file,
  output logic shadow_save,
  output logic tbl_go,
  output ofd_pkg::ofd_tmode_e tbl_mode,
  output logic [ofd_pkg::TPTR_W-1:0] table_pointer,
  output logic [ofd_pkg::TPTR_W-1:0] table_fetch_addr,
  output logic [7:0] table_latch,
  output ofd_pkg::ofd_flags_s status_flags
);
  // Field slices and decoded helpers
  logic [7:0] f8;
  logic a_bit;
  logic d_bit;
  logic [3:0] bank_eff;
  logic is_second;
  logic [20:0] rel_sext;
  logic [11:0] lit12;
  logic [19:0] lit20;
  logic [19:0] lit_sel;
  logic [7:0] bit_mask;
  logic [6:0] zs;
  logic [6:0] zd;
  ofd_pkg::ofd_tmode_e mode_dec;
  ofd_pkg::ofd_flags_s flags_q;
  ofd_pkg::ofd_flags_s flags_d;
  logic [7:0] lit8;
  logic [11:0] data_addr_w;
  logic [11:0] idx_src_w;
  logic [11:0] idx_dst_w;
  logic second_nop_w;

  // Format class helpers
  logic is_byte;
  logic is_bit;
  logic is_move;
  logic is_ctrl;
  logic is_table;
  logic act;

  // Decode two mode bits to a one-hot table mode
  // All four codes are legal; the default arm is what decodes code 0 to hold,
  // as no other arm covers it
  function automatic ofd_pkg::ofd_tmode_e tmode_of(input logic [1:0] m);
    ofd_pkg::ofd_tmode_e r;
    r = ofd_pkg::OFD_TM_NONE;
    case (m)
      2'h1: r = ofd_pkg::OFD_TM_POST_INC;
      2'h2: r = ofd_pkg::OFD_TM_POST_DEC;
      2'h3: r = ofd_pkg::OFD_TM_PRE_INC;
      default: r = ofd_pkg::OFD_TM_NONE;
    endcase
    return r;
  endfunction

  // Basic field extraction, all combinational within the issue cycle
  // The marker nibble is trusted only when the fetch flags a second word
  assign f8 = instr_word[7:0]; // RL5
  assign a_bit = instr_word[ofd_pkg::POS_A];
  assign d_bit = instr_word[ofd_pkg::POS_D];
  assign is_second = second_slot &&
    (instr_word[15:12] == ofd_pkg::MOVE_MARK); // RL15

  // Format class tests, shared by the strobes below
  assign is_byte = (fmt == ofd_pkg::OFD_FMT_BYTE);
  assign is_bit = (fmt == ofd_pkg::OFD_FMT_BIT);
  assign is_move = (fmt == ofd_pkg::OFD_FMT_MOVE);
  assign is_ctrl = (fmt == ofd_pkg::OFD_FMT_CTRL);
  assign is_table = (fmt == ofd_pkg::OFD_FMT_TABLE);

  // Access RAM ignores the bank register; offsets below 8'h60 bank 0, from 8'h60 up top
  // Split point and top bank are package constants; banked accesses
  // take the bank register whole, with no split
  assign bank_eff = a_bit ? bank_select_register : // RL2
    ((f8 < ofd_pkg::ACCESS_SPLIT) ? 4'h0 : ofd_pkg::ACCESS_HI_BANK); // RL1
  assign data_addr_w = {bank_eff, f8}; // RL2

  // Bit position and its one-hot mask
  // One comparator per bit keeps a shifter out of the path
  generate
    for (genvar i = 0; i < 8; i++) begin : g_mask
      assign bit_mask[i] = (instr_word[11:9] == 3'(i)); // RL3
    end
  endgenerate

  // Literal widths
  // The 20-bit form takes its low byte from the first word;
  // the short forms are zero extended
  assign lit8 = f8; // RL7
  assign lit12 = instr_word[11:0];
  assign lit20 = {instr_word[11:0], prev_word[7:0]};
  assign lit_sel = (lit_width == ofd_pkg::OFD_LIT20) ? lit20 :
                   (lit_width == ofd_pkg::OFD_LIT12) ? {8'h00, lit12} :
                   {12'h000, lit8}; // RL7

  // Signed branch offset, 11-bit or 8-bit field sign extended
  // Top bit of the width input picks the long form; the kind input
  // only says what the datapath will do with the result
  assign rel_sext = branch_rel_w[10] ?
    {{10{instr_word[10]}}, instr_word[10:0]} :
    {{13{instr_word[7]}}, instr_word[7:0]}; // RL11

  // Index offsets; sums wrap at the top of the 12-bit space
  assign zs = second_slot ? prev_word[6:0] : instr_word[6:0];
  assign zd = instr_word[6:0];
  assign idx_src_w = indirect_pointer_register + {5'h00, zs}; // RL12
  assign idx_dst_w = indirect_pointer_register + {5'h00, zd}; // RL12

  // A lone second word decodes as a no-operation
  assign second_nop_w = is_second && !is_move && !is_ctrl; // RL15
  assign mode_dec = tmode_of(instr_word[1:0]);

  // Operand bundle; bits outside each field are never looked at
  // Clearing first keeps every field defined on every path
  always_comb begin
    ops = '0; // RL13
    ops.data_addr = data_addr_w; // RL2
    ops.bit_pos = instr_word[11:9]; // RL3
    ops.bit_mask = bit_mask;
    ops.dest_file = d_bit; // RL4
    ops.ptr_sel = instr_word[5:4]; // RL5
    ops.move_src = prev_word[11:0]; // RL6
    ops.move_dst = instr_word[11:0]; // RL6
    ops.literal = lit_sel;
    ops.fast = instr_word[ofd_pkg::POS_S]; // RL8
    ops.branch_ofs = rel_sext[19:0]; // RL11
    ops.branch_abs = lit20; // RL11
    ops.idx_src = idx_src_w; // RL12
    ops.idx_dst = idx_dst_w; // RL12
    ops.second_nop = second_nop_w; // RL15
  end

  // Strobes are gated by the issue pulse; a lone second word raises no write or shadow strobe
  // A word that only carries operands must never write or touch shadows
  assign act = issue && !second_nop_w; // RL15
  assign ops_valid = issue; // RL16
  assign wr_accumulator = act && is_byte && !d_bit; // RL4
  assign wr_file = act && ((is_byte && d_bit) || is_bit ||
    (is_move && second_slot)); // RL4
  assign shadow_save = act && is_ctrl && instr_word[ofd_pkg::POS_S]; // RL8

  // Table operations are single-word, so no second-word gate
  assign tbl_go = issue && is_table; // RL9
  assign tbl_mode = mode_dec;

  // Status flags: masked update from the datapath
  // Unmasked flags keep their value through a write
  assign flags_d = flags_we ? ((flags_q & ~flags_mask) |
    (flags_in & flags_mask)) : flags_q; // RL14

  // Flag storage, cleared by reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_q <= ofd_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d; // RL14
    end
  end

  // Flags leave straight from the register
  assign status_flags = flags_q;

  // Table pointer and latch
  // Mode reaches the holder in the same cycle as its strobe
  ofd_table_ptr u_tbl (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tbl_go(tbl_go),
    .tbl_mode(mode_dec),
    .ptr_load(ptr_load),
    .ptr_load_val(ptr_load_val),
    .latch_load(latch_load),
    .latch_load_val(latch_load_val),
    .table_pointer(table_pointer),
    .fetch_addr(table_fetch_addr),
    .table_latch(table_latch)
  ); // RL10
endmodule

// >>> design/ofd_pkg.sv
// Package for the operand field decoder: field positions, widths, types.
// Assumes 16-bit instruction words and a single core clock.
package ofd_pkg;
  localparam int WORD_W = 16;
  localparam int FILE_W = 8;
  localparam int ADDR12_W = 12;
  localparam int TPTR_W = 21;
  localparam int BANK_W = 4;
  localparam int OFS_W = 7;
  localparam int PTR_SEL_W = 2;
  localparam int MOVE_MARK_W = 4;
  localparam logic [3:0] MOVE_MARK = 4'hf;
  localparam int POS_A = 8;
  localparam int POS_D = 9;
  localparam int POS_S = 0;
  localparam int POS_BIT_LO = 9;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [TPTR_W-1:0] TPTR_RST = 21'h000000;
  localparam logic [7:0] TLAT_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;

  // Instruction format class, one-hot
  typedef enum logic [6:0] {
    OFD_FMT_BYTE = 7'h01,
    OFD_FMT_BIT = 7'h02,
    OFD_FMT_LIT = 7'h04,
    OFD_FMT_MOVE = 7'h08,
    OFD_FMT_CTRL = 7'h10,
    OFD_FMT_TABLE = 7'h20,
    OFD_FMT_INDEX = 7'h40
  } ofd_fmt_e;

  // Table pointer modes as encoded in the two low bits
  typedef enum logic [3:0] {
    OFD_TM_NONE = 4'h1,
    OFD_TM_POST_INC = 4'h2,
    OFD_TM_POST_DEC = 4'h4,
    OFD_TM_PRE_INC = 4'h8
  } ofd_tmode_e;

  // Literal width selection
  typedef enum logic [2:0] {
    OFD_LIT8 = 3'h1,
    OFD_LIT12 = 3'h2,
    OFD_LIT20 = 3'h4
  } ofd_litw_e;

  // Status flags
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } ofd_flags_s;

  // Decoded operand bundle to the datapath
  typedef struct packed {
    logic [ADDR12_W-1:0] data_addr;
    logic [2:0] bit_pos;
    logic [7:0] bit_mask;
    logic dest_file;
    logic [PTR_SEL_W-1:0] ptr_sel;
    logic [ADDR12_W-1:0] move_src;
    logic [ADDR12_W-1:0] move_dst;
    logic [19:0] literal;
    logic fast;
    logic [19:0] branch_ofs;
    logic [19:0] branch_abs;
    logic [ADDR12_W-1:0] idx_src;
    logic [ADDR12_W-1:0] idx_dst;
    logic second_nop;
  } ofd_ops_s;
endpackage

// >>> design/ofd_table_ptr.sv
// Table pointer and table latch holding stage.
// Assumes mode and strobes are presented by the decoder in the same cycle.
`timescale 1ns/1ps
module ofd_table_ptr (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tbl_go,
  input wire ofd_pkg::ofd_tmode_e tbl_mode,
  input wire logic ptr_load,
  input wire logic [ofd_pkg::TPTR_W-1:0] ptr_load_val,
  input wire logic latch_load,
  input wire logic [7:0] latch_load_val,
  output logic [ofd_pkg::TPTR_W-1:0] table_pointer,
  output logic [ofd_pkg::TPTR_W-1:0] fetch_addr,
  output logic [7:0] table_latch
);
  logic [ofd_pkg::TPTR_W-1:0] ptr_q;
  logic [ofd_pkg::TPTR_W-1:0] ptr_d;
  logic [ofd_pkg::TPTR_W-1:0] ptr_inc;
  logic [ofd_pkg::TPTR_W-1:0] ptr_dec;
  logic [7:0] lat_q;

  // Pointer arithmetic for the four modes
  assign ptr_inc = ptr_q + ofd_pkg::TPTR_W'(1);
  assign ptr_dec = ptr_q - ofd_pkg::TPTR_W'(1);
  assign fetch_addr = (tbl_mode == ofd_pkg::OFD_TM_PRE_INC) ? ptr_inc : ptr_q; // RL9
  assign ptr_d = ptr_load ? ptr_load_val :
                 !tbl_go ? ptr_q :
                 (tbl_mode == ofd_pkg::OFD_TM_NONE) ? ptr_q :
                 (tbl_mode == ofd_pkg::OFD_TM_POST_DEC) ? ptr_dec :
                 ptr_inc; // RL9

  // Pointer and latch storage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptr_q <= ofd_pkg::TPTR_RST;
      lat_q <= ofd_pkg::TLAT_RST;
    end else begin
      ptr_q <= ptr_d; // RL10
      if (latch_load) begin
        lat_q <= latch_load_val; // RL10
      end
    end
  end

  assign table_pointer = ptr_q;
  assign table_latch = lat_q;
endmodule

// >>> bench/ofd_decoder_checker.sv
// Checker of the operand field decoder's port behaviour.
// Assumes binding to ofd_decoder, one clock, synchronous low reset.
`timescale 1ns/1ps
module ofd_decoder_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [15:0] instr_word,
  input wire logic second_slot,
  input wire ofd_pkg::ofd_fmt_e fmt,
  input wire logic [3:0] bank_select_register,
  input wire logic flags_we,
  input wire ofd_pkg::ofd_flags_s flags_in,
  input wire ofd_pkg::ofd_flags_s flags_mask,
  input wire logic ptr_load,
  input wire ofd_pkg::ofd_ops_s ops,
  input wire logic ops_valid,
  input wire logic wr_accumulator,
  input wire logic wr_file,
  input wire logic shadow_save,
  input wire logic tbl_go,
  input wire ofd_pkg::ofd_tmode_e tbl_mode,
  input wire logic [20:0] table_pointer,
  input wire ofd_pkg::ofd_flags_s status_flags
);
  // Qualified issue kinds
  wire byte_i = issue && !second_slot && fmt == ofd_pkg::OFD_FMT_BYTE;
  wire bit_i = issue && fmt == ofd_pkg::OFD_FMT_BIT;
  wire ctrl_i = issue && !second_slot && fmt == ofd_pkg::OFD_FMT_CTRL;
  wire nop_i = issue && second_slot && instr_word[15:12] == 4'hf &&
    !(fmt inside {ofd_pkg::OFD_FMT_MOVE, ofd_pkg::OFD_FMT_CTRL});
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Table operation that steps the pointer upward afterwards
  sequence s_post_inc;
    tbl_go && !ptr_load && tbl_mode == ofd_pkg::OFD_TM_POST_INC;
  endsequence
  AST_ACCESS_LOW: assert property (
    byte_i && !instr_word[8] && instr_word[7:0] < 8'h60 |->
    ops.data_addr == {4'h0, instr_word[7:0]})
    else $error("access bank address wrong");
  AST_BANKED: assert property (
    byte_i && instr_word[8] |->
    ops.data_addr == {bank_select_register, instr_word[7:0]})
    else $error("banked address wrong");
  AST_BIT_POS: assert property (
    bit_i |-> ops.bit_mask == 8'h01 << instr_word[11:9])
    else $error("bit mask wrong");
  AST_DEST: assert property (
    byte_i |-> wr_file == instr_word[9] && wr_accumulator == !instr_word[9])
    else $error("destination strobe wrong");
  AST_FAST: assert property (
    ctrl_i |-> shadow_save == instr_word[0])
    else $error("shadow strobe wrong");
  AST_TBL_STEP: assert property (
    s_post_inc |=> table_pointer == $past(table_pointer) + 21'h1)
    else $error("table pointer step wrong");
  AST_FLAGS: assert property (
    flags_we |=> status_flags == (($past(flags_in) & $past(flags_mask)) |
    ($past(status_flags) & ~$past(flags_mask))))
    else $error("status flags wrong");
  AST_SECOND_NOP: assert property (
    nop_i |-> ops.second_nop && !wr_file && !wr_accumulator && !shadow_save)
    else $error("lone second word not inert");
  AST_VALID: assert property (
    ops_valid == issue)
    else $error("operand valid wrong");
endmodule
bind ofd_decoder ofd_decoder_checker i_chk (.*);

// >>> bench/ofd_core_model.sv
// Datapath model holding bank select and indirect pointer state.
// Assumes loads come from the bench between issues.
`timescale 1ns/1ps
module ofd_core_model (
  input wire logic ref_clk,
  input wire logic ld,
  input wire logic [15:0] val,
  output logic [3:0] bank_select_register,
  output logic [11:0] indirect_pointer_register
);
  // State loads at the rising edge
  always_ff @(posedge ref_clk) begin
    if (ld) begin
      bank_select_register <= val[15:12];
      indirect_pointer_register <= val[11:0];
    end
  end
endmodule

// >>> bench/tb_ofd_decoder.sv
// Self-checking bench of the operand field decoder.
// Assumes the core model supplies bank and pointer state.
`timescale 1ns/1ps
module tb_ofd_decoder;
  logic ref_clk, rst_n, issue, second_slot, flags_we, ptr_load, ld;
  logic latch_load, ops_valid, wr_accumulator, wr_file, shadow_save, tbl_go;
  logic [15:0] instr_word, prev_word, lfsr_q;
  logic [20:0] ptr_load_val, table_pointer, table_fetch_addr, tp;
  logic [7:0] latch_load_val, table_latch;
  logic [3:0] bank;
  logic [11:0] iptr;
  logic [10:0] brw;
  logic [32:0] exp_q[$];
  logic [32:0] obs, exp_v;
  ofd_pkg::ofd_fmt_e fmt;
  ofd_pkg::ofd_litw_e lit_width;
  ofd_pkg::ofd_flags_s flags_in, flags_mask, status_flags;
  ofd_pkg::ofd_ops_s ops;
  ofd_pkg::ofd_tmode_e tbl_mode;
  int n_fail, tests_run;
  localparam logic [32:0] SKIP = 33'h100000000;
  ofd_core_model i_core (.ref_clk(ref_clk), .ld(ld), .val(16'ha123),
    .bank_select_register(bank), .indirect_pointer_register(iptr));
  ofd_decoder i_dut (.*, .branch_rel(1'b0), .branch_rel_w(brw),
    .bank_select_register(bank), .indirect_pointer_register(iptr));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [32:0] byte_exp(input logic [15:0] w);
    logic [3:0] b;
    b = w[8] ? 4'ha : (w[7:0] < 8'h60 ? 4'h0 : 4'hf);
    return {19'h0, !w[9], w[9], b, w[7:0]};
  endfunction
  // Issue one word and note its expected result
  task automatic put(input ofd_pkg::ofd_fmt_e f, input logic s,
    input logic [15:0] w, input logic [32:0] e);
    lfsr_q = nxt(lfsr_q);
    {flags_we, flags_in, flags_mask} = lfsr_q[10:0];
    fmt = f;
    second_slot = s;
    instr_word = w;
    issue = 1'b1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    prev_word = w;
  endtask
  task automatic stop_test();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Compare each issued result with the oldest note
  always @(posedge ref_clk) begin
    if (rst_n && ops_valid === 1'b1) begin
      exp_v = exp_q.pop_front();
      case (fmt)
        ofd_pkg::OFD_FMT_BYTE: obs = second_slot ?
          {ops.second_nop, wr_file, wr_accumulator} :
          {wr_accumulator, wr_file, ops.data_addr};
        ofd_pkg::OFD_FMT_BIT: obs = {ops.bit_pos, ops.bit_mask};
        ofd_pkg::OFD_FMT_MOVE: obs = {ops.move_src, ops.move_dst};
        ofd_pkg::OFD_FMT_LIT: obs = {ops.ptr_sel, ops.literal};
        ofd_pkg::OFD_FMT_CTRL: obs = second_slot ? ops.literal :
          {ops.branch_ofs, shadow_save};
        ofd_pkg::OFD_FMT_TABLE: obs = {table_latch, table_fetch_addr};
        default: obs = {ops.idx_src, ops.idx_dst};
      endcase
      if (!exp_v[32]) begin
        tests_run++;
        if (obs !== exp_v) begin
          n_fail++;
          $display("ERROR t=%0t exp=%h got=%h", $time, exp_v, obs);
        end
      end
    end
  end
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    {rst_n, issue, second_slot, flags_we, latch_load} = 5'h00;
    {instr_word, prev_word, flags_in, flags_mask} = 42'h0;
    fmt = ofd_pkg::OFD_FMT_BYTE;
    lit_width = ofd_pkg::OFD_LIT8;
    latch_load_val = 8'h00;
    brw = 11'h000;
    lfsr_q = 16'h001e;
    ld = 1'b1;
    ptr_load = 1'b1;
    ptr_load_val = 21'h1ffffe;
    tp = 21'h1ffffe;
    repeat (17) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    {ld, ptr_load} = 2'b00;
    for (int i = 0; i < 10; i++) begin
      put(ofd_pkg::OFD_FMT_BYTE, 1'b0, i < 2 ? 16'h005f + 16'(i) : lfsr_q,
        byte_exp(i < 2 ? 16'h005f + 16'(i) : lfsr_q));
    end
    put(ofd_pkg::OFD_FMT_BYTE, 1'b1, 16'hf3a5, 33'h4);
    $display("byte test done");
    for (int b = 0; b < 8; b++) begin
      put(ofd_pkg::OFD_FMT_BIT, 1'b0, {4'h8, 3'(b), 9'h012},
        {3'(b), 8'h01 << b});
    end
    put(ofd_pkg::OFD_FMT_MOVE, 1'b0, 16'hcfff, SKIP);
    put(ofd_pkg::OFD_FMT_MOVE, 1'b1, 16'hf000, 33'hfff000);
    lit_width = ofd_pkg::OFD_LIT12;
    put(ofd_pkg::OFD_FMT_LIT, 1'b0, 16'h0e1c, 33'h100e1c);
    lit_width = ofd_pkg::OFD_LIT8;
    put(ofd_pkg::OFD_FMT_LIT, 1'b0, 16'h0e7f, 33'h30007f);
    put(ofd_pkg::OFD_FMT_CTRL, 1'b0, 16'hec5b, 33'hb7);
    put(ofd_pkg::OFD_FMT_CTRL, 1'b0, 16'hec12, 33'h24);
    lit_width = ofd_pkg::OFD_LIT20;
    put(ofd_pkg::OFD_FMT_CTRL, 1'b1, 16'hf123, 33'h12312);
    brw = 11'h400;
    put(ofd_pkg::OFD_FMT_CTRL, 1'b0, 16'hd7f0, 33'h1fffe0);
    brw = 11'h000;
    put(ofd_pkg::OFD_FMT_CTRL, 1'b0, 16'he085, 33'h1fff0b);
    $display("field test done");
    latch_load = 1'b1;
    latch_load_val = 8'h5c;
    for (int m = 3; m >= 0; m--) begin
      // Don't-care bits hold a single 1 at bit 3; latch shows its reset value first
      put(ofd_pkg::OFD_FMT_TABLE, 1'b0, {14'h0002, 2'(m)},
        {(m == 3 ? 8'h00 : 8'h5c),
        (m == 3 ? tp + 21'h1 : tp)});
      latch_load = 1'b0;
      tp = m == 2 ? tp - 21'h1 : (m == 0 ? tp : tp + 21'h1);
    end
    put(ofd_pkg::OFD_FMT_INDEX, 1'b0, 16'h007f, 33'h1a21a2);
    put(ofd_pkg::OFD_FMT_INDEX, 1'b1, 16'hf005, 33'h1a2128);
    put(ofd_pkg::OFD_FMT_INDEX, 1'b0, 16'h0000, 33'h123123);
    issue = 1'b0;
    flags_we = 1'b0;
    repeat (2) @(negedge ref_clk);
    $display("table and index test done");
    if (exp_q.size() != 0) begin
      n_fail++;
    end
    stop_test();
  end
endmodule
